// *** src/halt_ctrl_pkg.sv ***
// package of constants and carrier types for the stop mode controller
package halt_ctrl_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] IRQ_OFS    = 8'h08;
    localparam logic [7:0] MASK_OFS   = 8'h0C;

    // control field positions
    localparam int HALT_PERMIT_BIT = 0;
    localparam int REF_KEEP_BIT    = 1;
    localparam int BO_ON_BIT       = 2;
    localparam int BO_HALT_BIT     = 3;
    localparam int DBG_PERMIT_BIT  = 4;
    localparam int BO_RESET_BIT    = 5;
    localparam int WAKE_EN_LSB     = 8;
    localparam int PWS_LSB         = 16;

    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [5:0]  MASK_RESET = 6'h00;

    // event bit positions (sticky status)
    localparam int EV_STOP  = 0;
    localparam int EV_WAKE  = 1;
    localparam int EV_ILLOP = 2;
    localparam int EV_BO    = 3;
    localparam int EV_DBG   = 4;
    localparam int EV_REJ   = 5;

    // restart sync depth and fetch address after reset wake
    localparam logic [1:0]  SYNC_STAGES = 2'h2;
    localparam logic [15:0] RESET_FETCH = 16'h3FFD;

    // periodic timer: 1 kHz tick derived at 250 MHz
    localparam int CLK_HZ      = 250_000_000;
    localparam int SLOW_HZ     = 1_000;
    localparam int SLOW_CYCLES = CLK_HZ / SLOW_HZ;

    // mode states
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_STOP  = 2'b01,
        ST_SYNC  = 2'b10,
        ST_DEBUG = 2'b11
    } mode_t;

    // control fields
    typedef struct packed {
        logic [2:0] pws;
        logic [2:0] wake_en;
        logic       bo_reset;
        logic       dbg_permit;
        logic       bo_halt;
        logic       bo_on;
        logic       ref_keep;
        logic       halt_permit;
    } ctrl_t;

    // outputs toward the power and clock fabric
    typedef struct packed {
        logic core_clk_en;
        logic periph_clk_en;
        logic clkgen_en;
        logic ref32_en;
        logic slow_osc_en;
        logic dbg_clk_en;
        logic reg_full;
        logic pin_hold;
        logic illop_rst;
        logic bo_rst;
        logic full_rst;
        logic resume;
        logic dbg_enter;
        logic dbg_err;
        logic dbg_ack;
    } pwr_t;

endpackage

// *** src/stop_mode_controller.sv ***
// stop mode controller: halt entry, clock gating, wake and debug handling
//------------------------------------------------------------------------
// What this block does
// - permitted halt enters stop, gates clocks
// - halt without permit forces illegal-opcode reset
// - no keepalive: clock generator off; regulator standby unless debug permit or brownout in halt
// - state, RAM and pin levels held
// - wake on reset, enabled async, timer
// - reset wake performs full reset at 3FFD
// - interrupt wake resumes after halt, no vector
// - timer on 1 kHz; select 000 disables
// - 32 kHz runs only with keepalive and brownout bits
// - debug entry from run needs debug permit
// - debug permit keeps debug clocks, full regulation
// - status commands refused with stop error
// - enter command wakes into debug if permitted
// - debug entered from stop accepts all commands
// - brownout raises interrupt or reset
// - brownout in halt keeps regulator active
//------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module stop_mode_controller (
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        RESET,
    // axi4-lite write address
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    // axi4-lite write data
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    // axi4-lite write response
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    // axi4-lite read address
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    // axi4-lite read data
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    // core and wake sources
    input  wire logic        HALT_EXEC,
    input  wire logic        RESET_PIN,
    input  wire logic        KEYPAD_WAKE,
    input  wire logic        BROWNOUT_TRIP,
    input  wire logic        COMPARE_WAKE,
    // debug command strobes
    input  wire logic        DBG_STATUS_CMD,
    input  wire logic        DBG_ENTER_CMD,
    input  wire logic        DBG_GO_CMD,
    // power and clock controls
    output logic             CORE_CLK_EN,
    output logic             PERIPH_CLK_EN,
    output logic             CLKGEN_EN,
    output logic             REF32_EN,
    output logic             SLOW_OSC_EN,
    output logic             DBG_CLK_EN,
    output logic             REG_FULL,
    output logic             PIN_HOLD,
    output logic             ILLOP_RST,
    output logic             BO_RST,
    output logic             FULL_RST,
    output logic [15:0]      FETCH_ADDR,
    output logic             RESUME,
    output logic             DBG_ENTER,
    output logic             DBG_ERR,
    output logic             DBG_ACK,
    output logic             DEBUG_ACTIVE,
    output logic             IRQ
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        halt_ctrl_pkg::mode_t mode;
        halt_ctrl_pkg::ctrl_t ctrl;
        logic [5:0]           sts;
        logic [5:0]           mask;
        logic [1:0]           sync;
        logic [17:0]          div;
        logic [9:0]           ptmr;
        logic                 aw_got;
        logic                 w_got;
        logic [7:0]           awaddr;
        logic [31:0]          wdata;
        logic [3:0]           wstrb;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
        halt_ctrl_pkg::pwr_t  pwr;
        logic [15:0]          fetch;
        logic                 irq;
    } state_t;

    state_t s_q;
    state_t s_d;

    // ----------------------------------------------------------------
    // combinational helpers
    // ----------------------------------------------------------------
    logic       slow_tick;
    logic       timer_wake;
    logic       async_wake;
    logic       bo_halt_on;
    logic [5:0] ev;
    logic       wr_fire;
    logic [7:0] rd_addr;

    // periodic timer period selected by the 3-bit select
    function automatic logic [9:0] period(input logic [2:0] sel);
        period = 10'(10'h001 << sel);
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d        = s_q;
        bo_halt_on = s_q.ctrl.bo_on && s_q.ctrl.bo_halt;
        ev         = 6'h00;
        // 1 kHz enable pulse from divider; select 000 stops it
        slow_tick  = 1'b0;
        timer_wake = 1'b0;
        if (s_q.ctrl.pws != 3'b000) begin
            if (s_q.div == 18'(halt_ctrl_pkg::SLOW_CYCLES - 1)) begin
                s_d.div   = 18'h00000;
                slow_tick = 1'b1;
            end else begin
                s_d.div = s_q.div + 18'h00001;
            end
            if (slow_tick) begin
                if (s_q.ptmr >= period(s_q.ctrl.pws) - 10'h001) begin
                    s_d.ptmr   = 10'h000;
                    timer_wake = 1'b1;
                end else begin
                    s_d.ptmr = s_q.ptmr + 10'h001;
                end
            end
        end else begin
            s_d.div  = 18'h00000;
            s_d.ptmr = 10'h000;
        end
        async_wake = (KEYPAD_WAKE && s_q.ctrl.wake_en[0])
                   || (BROWNOUT_TRIP && s_q.ctrl.wake_en[1] && s_q.ctrl.bo_on)
                   || (COMPARE_WAKE && s_q.ctrl.wake_en[2]);

        // one-cycle pulses default low
        s_d.pwr.illop_rst = 1'b0;
        s_d.pwr.bo_rst    = 1'b0;
        s_d.pwr.full_rst  = 1'b0;
        s_d.pwr.resume    = 1'b0;
        s_d.pwr.dbg_enter = 1'b0;
        s_d.pwr.dbg_err   = 1'b0;
        s_d.pwr.dbg_ack   = 1'b0;

        // brownout: reset or interrupt event
        if (BROWNOUT_TRIP && s_q.ctrl.bo_on) begin
            ev[halt_ctrl_pkg::EV_BO] = 1'b1;
            s_d.pwr.bo_rst = s_q.ctrl.bo_reset;
        end

        // mode sequencing
        case (s_q.mode)
            halt_ctrl_pkg::ST_RUN: begin
                if (HALT_EXEC && s_q.ctrl.halt_permit) begin
                    s_d.mode = halt_ctrl_pkg::ST_STOP;
                    ev[halt_ctrl_pkg::EV_STOP] = 1'b1;
                    s_d.pwr.core_clk_en   = 1'b0;
                    s_d.pwr.periph_clk_en = 1'b0;
                    s_d.pwr.pin_hold      = 1'b1;
                    // clock generator only with keepalive and brownout bits
                    s_d.pwr.clkgen_en = s_q.ctrl.ref_keep && bo_halt_on;
                    s_d.pwr.ref32_en  = s_q.ctrl.ref_keep && bo_halt_on;
                    s_d.pwr.dbg_clk_en = s_q.ctrl.dbg_permit;
                    s_d.pwr.reg_full = s_q.ctrl.dbg_permit || bo_halt_on;
                end else if (HALT_EXEC) begin
                    s_d.pwr.illop_rst = 1'b1;
                    ev[halt_ctrl_pkg::EV_ILLOP] = 1'b1;
                end else if (DBG_ENTER_CMD && s_q.ctrl.dbg_permit) begin
                    s_d.mode = halt_ctrl_pkg::ST_DEBUG;
                    s_d.pwr.dbg_enter = 1'b1;
                    s_d.pwr.dbg_ack   = 1'b1;
                    ev[halt_ctrl_pkg::EV_DBG] = 1'b1;
                end else if (DBG_STATUS_CMD) begin
                    s_d.pwr.dbg_ack = 1'b1;
                end
            end
            halt_ctrl_pkg::ST_STOP: begin
                if (RESET_PIN) begin
                    s_d.mode          = halt_ctrl_pkg::ST_RUN;
                    s_d.pwr.full_rst  = 1'b1;
                    s_d.fetch         = halt_ctrl_pkg::RESET_FETCH;
                    s_d.pwr.core_clk_en   = 1'b1;
                    s_d.pwr.periph_clk_en = 1'b1;
                    s_d.pwr.clkgen_en = 1'b1;
                    s_d.pwr.reg_full  = 1'b1;
                    s_d.pwr.pin_hold  = 1'b0;
                    s_d.pwr.ref32_en  = 1'b0;
                end else if (DBG_ENTER_CMD && s_q.ctrl.dbg_permit) begin
                    s_d.mode = halt_ctrl_pkg::ST_SYNC;
                    s_d.sync = 2'h0;
                    s_d.pwr.dbg_ack = 1'b1;
                    s_d.pwr.clkgen_en = 1'b1;
                    s_d.pwr.reg_full  = 1'b1;
                end else if (async_wake || timer_wake) begin
                    s_d.mode = halt_ctrl_pkg::ST_SYNC;
                    s_d.sync = 2'h1;
                    s_d.pwr.clkgen_en = 1'b1;
                    s_d.pwr.reg_full  = 1'b1;
                end else if (DBG_STATUS_CMD) begin
                    s_d.pwr.dbg_err = 1'b1;
                    s_d.pwr.dbg_ack = 1'b1;
                    ev[halt_ctrl_pkg::EV_REJ] = 1'b1;
                end
            end
            halt_ctrl_pkg::ST_SYNC: begin
                // hold the core until the restarted clock settles
                // interrupt wake runs 1 then 3, debug wake 0 then 2
                s_d.ptmr = s_q.ptmr;
                if (s_q.sync[0] == 1'b1 && s_q.sync[1] == 1'b1) begin
                    s_d.mode = halt_ctrl_pkg::ST_RUN;
                    s_d.pwr.resume = 1'b1;
                    s_d.pwr.core_clk_en   = 1'b1;
                    s_d.pwr.periph_clk_en = 1'b1;
                    s_d.pwr.pin_hold  = 1'b0;
                    s_d.pwr.ref32_en  = 1'b0;
                    ev[halt_ctrl_pkg::EV_WAKE] = 1'b1;
                end else if (s_q.sync == halt_ctrl_pkg::SYNC_STAGES) begin
                    s_d.mode = halt_ctrl_pkg::ST_DEBUG;
                    s_d.pwr.dbg_enter = 1'b1;
                    s_d.pwr.pin_hold  = 1'b0;
                    s_d.pwr.ref32_en  = 1'b0;
                    s_d.pwr.periph_clk_en = 1'b1;
                    ev[halt_ctrl_pkg::EV_DBG] = 1'b1;
                end else begin
                    s_d.sync = s_q.sync + 2'h2;
                end
            end
            halt_ctrl_pkg::ST_DEBUG: begin
                // every command type answered normally
                if (DBG_STATUS_CMD || DBG_ENTER_CMD) begin
                    s_d.pwr.dbg_ack = 1'b1;
                end
                if (DBG_GO_CMD) begin
                    s_d.mode = halt_ctrl_pkg::ST_RUN;
                    s_d.pwr.dbg_ack     = 1'b1;
                    s_d.pwr.core_clk_en = 1'b1;
                    s_d.pwr.dbg_clk_en  = 1'b1;
                end
            end
            default: s_d.mode = halt_ctrl_pkg::ST_RUN;
        endcase
        s_d.pwr.slow_osc_en = (s_q.ctrl.pws != 3'b000);

        // register bus: write channels taken in either order
        if (AWVALID && !s_q.aw_got && !s_q.bvalid) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = AWADDR;
        end
        if (WVALID && !s_q.w_got && !s_q.bvalid) begin
            s_d.w_got = 1'b1;
            s_d.wdata = WDATA;
            s_d.wstrb = WSTRB;
        end
        wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
        // response code stands with bvalid until taken
        if (wr_fire) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = 2'b00;
            case (s_q.awaddr)
                halt_ctrl_pkg::CTRL_OFS: begin
                    if (s_q.wstrb[0]) s_d.ctrl[5:0] = s_q.wdata[5:0];
                    if (s_q.wstrb[1]) s_d.ctrl[8:6] = s_q.wdata[10:8];
                    if (s_q.wstrb[2]) s_d.ctrl[11:9] = s_q.wdata[18:16];
                end
                halt_ctrl_pkg::IRQ_OFS: s_d.sts = s_q.sts & ~s_q.wdata[5:0];
                halt_ctrl_pkg::MASK_OFS: s_d.mask = s_q.wdata[5:0];
                halt_ctrl_pkg::STATUS_OFS: ;
                default: s_d.bresp = 2'b10;
            endcase
        end else if (s_q.bvalid && BREADY) begin
            s_d.bvalid = 1'b0;
        end
        // sticky events: set wins over clear
        s_d.sts = s_d.sts | ev;
        s_d.irq = |(s_d.sts & s_d.mask);

        // read channel
        rd_addr = ARADDR;
        if (ARVALID && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = 2'b00;
            case (rd_addr)
                halt_ctrl_pkg::CTRL_OFS: s_d.rdata = {13'h0000, s_q.ctrl.pws, 5'h00,
                    s_q.ctrl.wake_en, 2'h0, s_q.ctrl[5:0]};
                halt_ctrl_pkg::STATUS_OFS: s_d.rdata = {28'h0000000,
                    s_q.pwr.reg_full, s_q.pwr.clkgen_en, s_q.mode};
                halt_ctrl_pkg::IRQ_OFS:  s_d.rdata = {26'h0000000, s_q.sts};
                halt_ctrl_pkg::MASK_OFS: s_d.rdata = {26'h0000000, s_q.mask};
                default: begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.rresp = 2'b10;
                end
            endcase
        end else if (s_q.rvalid && RREADY) begin
            s_d.rvalid = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // register the state
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            s_q      <= '0;
            s_q.mode <= halt_ctrl_pkg::ST_RUN;
            s_q.ctrl <= halt_ctrl_pkg::ctrl_t'(halt_ctrl_pkg::CTRL_RESET[11:0]);
            s_q.mask <= halt_ctrl_pkg::MASK_RESET;
            s_q.pwr.core_clk_en   <= 1'b1;
            s_q.pwr.periph_clk_en <= 1'b1;
            s_q.pwr.clkgen_en     <= 1'b1;
            s_q.pwr.reg_full      <= 1'b1;
            s_q.pwr.dbg_clk_en    <= 1'b1;
            s_q.fetch <= halt_ctrl_pkg::RESET_FETCH;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs straight from flops
    // ----------------------------------------------------------------
    assign AWREADY       = !s_q.aw_got && !s_q.bvalid;
    assign WREADY        = !s_q.w_got && !s_q.bvalid;
    assign BVALID        = s_q.bvalid;
    assign BRESP         = s_q.bresp;
    assign ARREADY       = !s_q.rvalid;
    assign RVALID        = s_q.rvalid;
    assign RDATA         = s_q.rdata;
    assign RRESP         = s_q.rresp;
    assign CORE_CLK_EN   = s_q.pwr.core_clk_en;
    assign PERIPH_CLK_EN = s_q.pwr.periph_clk_en;
    assign CLKGEN_EN     = s_q.pwr.clkgen_en;
    assign REF32_EN      = s_q.pwr.ref32_en;
    assign SLOW_OSC_EN   = s_q.pwr.slow_osc_en;
    assign DBG_CLK_EN    = s_q.pwr.dbg_clk_en;
    assign REG_FULL      = s_q.pwr.reg_full;
    assign PIN_HOLD      = s_q.pwr.pin_hold;
    assign ILLOP_RST     = s_q.pwr.illop_rst;
    assign BO_RST        = s_q.pwr.bo_rst;
    assign FULL_RST      = s_q.pwr.full_rst;
    assign FETCH_ADDR    = s_q.fetch;
    assign RESUME        = s_q.pwr.resume;
    assign DBG_ENTER     = s_q.pwr.dbg_enter;
    assign DBG_ERR       = s_q.pwr.dbg_err;
    assign DBG_ACK       = s_q.pwr.dbg_ack;
    assign DEBUG_ACTIVE  = (s_q.mode == halt_ctrl_pkg::ST_DEBUG);
    assign IRQ           = s_q.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_halt_gate;
        @(posedge MCLK) disable iff (RESET)
        (DEBUG_ACTIVE == 1'b0 && s_q.mode == halt_ctrl_pkg::ST_RUN && HALT_EXEC
            && s_q.ctrl.halt_permit) |=> (!CORE_CLK_EN && !PERIPH_CLK_EN && PIN_HOLD);
    endproperty
    a_halt_gate: assert property (p_halt_gate) else $error("halt did not gate clocks");

    property p_illop;
        @(posedge MCLK) disable iff (RESET)
        (s_q.mode == halt_ctrl_pkg::ST_RUN && HALT_EXEC && !s_q.ctrl.halt_permit)
            |=> (ILLOP_RST && CORE_CLK_EN);
    endproperty
    a_illop: assert property (p_illop) else $error("no illegal-opcode reset");

    property p_regulator;
        @(posedge MCLK) disable iff (RESET)
        (s_q.mode == halt_ctrl_pkg::ST_RUN && HALT_EXEC && s_q.ctrl.halt_permit)
            |=> (REG_FULL == $past(s_q.ctrl.dbg_permit || bo_halt_on));
    endproperty
    a_regulator: assert property (p_regulator) else $error("regulator state wrong");

    property p_ref32;
        @(posedge MCLK) disable iff (RESET)
        (s_q.mode == halt_ctrl_pkg::ST_STOP && REF32_EN)
            |-> (s_q.ctrl.ref_keep && s_q.ctrl.bo_on && s_q.ctrl.bo_halt);
    endproperty
    a_ref32: assert property (p_ref32) else $error("32 kHz ran without keepalive");

    property p_reset_wake;
        @(posedge MCLK) disable iff (RESET)
        (s_q.mode == halt_ctrl_pkg::ST_STOP && RESET_PIN)
            |=> (FULL_RST && FETCH_ADDR == halt_ctrl_pkg::RESET_FETCH && CORE_CLK_EN);
    endproperty
    a_reset_wake: assert property (p_reset_wake) else $error("reset wake wrong");

    property p_sync_resume;
        @(posedge MCLK) disable iff (RESET)
        (s_q.mode == halt_ctrl_pkg::ST_STOP && !RESET_PIN && !DBG_ENTER_CMD && async_wake)
            |=> !CORE_CLK_EN ##2 (RESUME && CORE_CLK_EN);
    endproperty
    a_sync_resume: assert property (p_sync_resume) else $error("resume not after sync");

    property p_status_err;
        @(posedge MCLK) disable iff (RESET)
        (s_q.mode == halt_ctrl_pkg::ST_STOP && DBG_STATUS_CMD && !RESET_PIN
            && !DBG_ENTER_CMD && !async_wake && !timer_wake) |=> (DBG_ERR && DBG_ACK);
    endproperty
    a_status_err: assert property (p_status_err) else $error("stop status not refused");

    property p_dbg_permit;
        @(posedge MCLK) disable iff (RESET)
        DBG_ENTER |-> $past(s_q.ctrl.dbg_permit, 1) || $past(s_q.ctrl.dbg_permit, 3);
    endproperty
    a_dbg_permit: assert property (p_dbg_permit) else $error("debug entered unpermitted");

    property p_no_timer;
        @(posedge MCLK) disable iff (RESET)
        (s_q.ctrl.pws == 3'b000) |-> (!timer_wake && !slow_tick);
    endproperty
    a_no_timer: assert property (p_no_timer) else $error("timer ran while disabled");

endmodule

`default_nettype wire

// *** verif/stop_mode_controller_bench.sv ***
// self-checking bench for the stop mode controller
`timescale 1ns/1ps
`default_nettype none

module stop_mode_controller_bench;
    logic        mclk = '0, reset = '1, awvalid = '0, wvalid = '0, bready = '0;
    logic        arvalid = '0, rready = '0, key = '0;
    logic        bo = '0, cmpw = '0;
    logic [4:0]  strb = '0; // halt, reset pin, status, enter, go
    localparam int halt = 0, rpin = 1, dst = 2, den = 3, dgo = 4;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = '0;
    logic [1:0]  bresp, rresp;
    logic [15:0] fetch;
    logic        awready, wready, bvalid, arready, rvalid, core, per, cgen, r32, slow;
    logic        dclk, regf, hold, ill, bor, frst, res, dent, derr, dack, dact, irq;
    int          num_errors = 0, n_checks = 0;

    // ------------------------------------------------------------
    // design and clock
    // ------------------------------------------------------------
    stop_mode_controller DUT (.MCLK(mclk), .RESET(reset), .AWADDR(awaddr),
        .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
        .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .HALT_EXEC(strb[0]), .RESET_PIN(strb[1]), .KEYPAD_WAKE(key), .BROWNOUT_TRIP(bo),
        .COMPARE_WAKE(cmpw), .DBG_STATUS_CMD(strb[2]), .DBG_ENTER_CMD(strb[3]),
        .DBG_GO_CMD(strb[4]), .CORE_CLK_EN(core), .PERIPH_CLK_EN(per), .CLKGEN_EN(cgen),
        .REF32_EN(r32), .SLOW_OSC_EN(slow), .DBG_CLK_EN(dclk), .REG_FULL(regf),
        .PIN_HOLD(hold), .ILLOP_RST(ill), .BO_RST(bor), .FULL_RST(frst),
        .FETCH_ADDR(fetch), .RESUME(res), .DBG_ENTER(dent), .DBG_ERR(derr),
        .DBG_ACK(dack), .DEBUG_ACTIVE(dact), .IRQ(irq));
    always #2 mclk = ~mclk;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task summarize;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // axi4-lite write, each channel released once taken
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge mclk);
        awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        chk(bresp, e);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge mclk);
        araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
        chk(rdata, d);
        chk(rresp, e);
    endtask
    // one-cycle strobe on a core or debug line, then settle
    task pulse(input int k);
        @(posedge mclk);
        strb[k] <= 1'h1;
        @(posedge mclk);
        strb[k] <= 1'h0;
        #1;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_regs;
        rd(halt_ctrl_pkg::CTRL_OFS, 32'h0, 2'h0);
        chk(slow, 1'h0);
        pulse(den);
        chk({dent, dact}, 2'h0);
        rd(8'h10, 32'h0, 2'h2); // unmapped read refused
        wr(8'h10, 32'hFF, 2'h2);
    endtask
    task t_illop;
        wr(halt_ctrl_pkg::MASK_OFS, 32'h4, 2'h0);
        pulse(halt);
        chk(ill, 1'h1);
        chk(core, 1'h1);
        repeat (2) @(posedge mclk);
        #1 chk(irq, 1'h1);
        rd(halt_ctrl_pkg::IRQ_OFS, 32'h4, 2'h0);
        wr(halt_ctrl_pkg::IRQ_OFS, 32'h4, 2'h0);
        repeat (2) @(posedge mclk);
        #1 chk(irq, 1'h0);
    endtask
    task t_stop;
        wr(halt_ctrl_pkg::CTRL_OFS, 32'h101, 2'h0);
        pulse(halt);
        chk({core, per, cgen, regf, hold}, 5'h01);
        chk(irq, 1'h0);
        rd(halt_ctrl_pkg::STATUS_OFS, 32'h1, 2'h0);
        @(posedge mclk);
        key <= 1'h1;
        repeat (2) @(posedge mclk);
        #1 chk(core, 1'h0);
        @(posedge mclk);
        #1 chk({res, core}, 2'h3);
        @(posedge mclk);
        key <= 1'h0;
    endtask
    task t_rstwake;
        pulse(halt);
        pulse(rpin);
        chk(frst, 1'h1);
        chk(fetch, halt_ctrl_pkg::RESET_FETCH);
        chk(core, 1'h1);
        repeat (4) @(posedge mclk);
    endtask
    task t_dbg;
        wr(halt_ctrl_pkg::CTRL_OFS, 32'h11, 2'h0);
        pulse(halt);
        chk({dclk, regf, core}, 3'h6);
        pulse(dst);
        chk({derr, dack}, 2'h3);
        pulse(den);
        chk(dack, 1'h1);
        repeat (2) @(posedge mclk);
        #1 chk({dent, dact}, 2'h3);
        pulse(dst);
        chk({derr, dack}, 2'h1);
        pulse(dgo);
        chk({core, dact}, 2'h2);
    endtask
    task t_bo;
        wr(halt_ctrl_pkg::CTRL_OFS, 32'h1022F, 2'h0);
        rd(halt_ctrl_pkg::CTRL_OFS, 32'h1022F, 2'h0);
        chk(slow, 1'h1);
        pulse(halt);
        chk({cgen, r32, regf, dclk}, 4'hE);
        @(posedge mclk);
        bo <= 1'h1;
        @(posedge mclk);
        #1 chk(bor, 1'h1);
        repeat (2) @(posedge mclk);
        #1 chk({res, core}, 2'h3);
        @(posedge mclk);
        bo <= 1'h0;
    endtask

    initial begin
        #200000;
        num_errors++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'h0;
        t_regs();
        t_illop();
        t_stop();
        t_rstwake();
        t_dbg();
        t_bo();
        summarize();
    end
endmodule

`default_nettype wire
